// *** core/windowed_watchdog_control.v ***
`include "wdog_defs.vh"
module windowed_watchdog_control
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        special_mode,
   input  wire        debug_mode,
   output reg         system_reset,
   output reg         periodic_freeze,
   output reg         irq
);
   reg  [1:0]  special_sync_q;
   reg  [1:0]  debug_sync_q;
   reg         window_q;
   reg         debug_stop_q;
   reg  [2:0]  rate_q;
   reg         written_q;
   reg         armed_q;
   reg         restart_q;
   reg  [`IRQ_WIDTH-1:0] status_q;
   reg  [`IRQ_WIDTH-1:0] mask_q;
   reg  [`IRQ_WIDTH-1:0] event_d;
   reg         restart_d;
   reg         fail_d;
   wire        special;
   wire        debug;
   wire        enabled;
   wire        override;
   wire [2:0]  eff_rate;
   wire        eff_window;
   wire        freeze;
   wire        expired;
   wire        in_window;
   wire        access;
   wire        wr;
   reg         hit_ctrl;
   reg         hit_svc;
   reg         hit_stat;
   reg         hit_mask;
   reg         hit_none;
   reg  [31:0] rdata_d;
   wire        may_cfg;
   wire [7:0]  wbyte;

   // Offsets count words, not bytes: the byte address is four times the index.
   function [11:0] byte_addr;
      input [11:0] index;
      begin
         byte_addr = {index[9:0], 2'b00};
      end
   endfunction

   function [31:0] irq_word;
      input [`IRQ_WIDTH-1:0] bits;
      begin
         irq_word = {{(32-`IRQ_WIDTH){1'b0}}, bits};
      end
   endfunction

   // Bits 5 to 3 keep no storage, and the write mask is never read back.
   function [31:0] control_word;
      input       win;
      input       stop;
      input [2:0] rate;
      begin
         control_word = {24'h000000, win, stop, 3'b000, rate};
      end
   endfunction

   // Mode straps are pins, so they pass two flops before use.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         special_sync_q <= 2'b00;
         debug_sync_q   <= 2'b00;
      end
      else
      begin
         special_sync_q <= {special_sync_q[0], special_mode};
         debug_sync_q   <= {debug_sync_q[0], debug_mode};
      end
   end
   assign special = special_sync_q[1];
   assign debug   = debug_sync_q[1];

   assign access   = psel && penable;
   assign wr       = access && pwrite;
   assign wbyte    = pwdata[7:0];
   assign may_cfg  = special || !written_q;

   // Only one select can be high, and an unmapped address raises hit_none.
   always @*
   begin
      hit_ctrl = 1'b0;
      hit_svc  = 1'b0;
      hit_stat = 1'b0;
      hit_mask = 1'b0;
      hit_none = 1'b0;
      if (paddr == byte_addr(`OFF_CONTROL))
         hit_ctrl = 1'b1;
      else if (paddr == byte_addr(`OFF_SERVICE))
         hit_svc = 1'b1;
      else if (paddr == byte_addr(`OFF_IRQ_STATUS))
         hit_stat = 1'b1;
      else if (paddr == byte_addr(`OFF_IRQ_MASK))
         hit_mask = 1'b1;
      else
         hit_none = 1'b1;
   end

   always @*
   begin
      rdata_d = 32'h00000000;
      if (hit_ctrl)
         rdata_d = control_word(window_q, debug_stop_q, rate_q);
      else if (hit_stat)
         rdata_d = irq_word(status_q);
      else if (hit_mask)
         rdata_d = irq_word(mask_q);
      // The service register has no read path and reads zero.
   end

   // A halted core in special modes must not be reset by a short period.
   assign enabled  = (rate_q != 3'h0);
   assign override = enabled && debug && !debug_stop_q && special;
   assign eff_rate   = override ? `RATE_MAX : rate_q;
   assign eff_window = override ? 1'b0 : window_q;
   assign freeze     = debug && debug_stop_q;

   wdog_counter u_counter
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .restart   (restart_q),
      .run       (enabled),
      .freeze    (freeze),
      .rate      (eff_rate),
      .expired   (expired),
      .in_window (in_window)
   );

   always @*
   begin
      restart_d = 1'b0;
      fail_d    = 1'b0;
      event_d   = {`IRQ_WIDTH{1'b0}};
      if (wr && hit_ctrl)
      begin
         if (!wbyte[`BIT_WRITE_MASK] && may_cfg && wbyte[2:0] != 3'h0)
            restart_d = 1'b1;
         if (wbyte[`BIT_DEBUG_STOP] && !debug_stop_q)
            restart_d = 1'b1;
      end
      // An early or bad write resets even while a pair is pending.
      if (wr && hit_svc && enabled)
      begin
         if (eff_window && !in_window)
         begin
            fail_d = 1'b1;
            event_d[`IRQ_EARLY] = 1'b1;
         end
         else if (wbyte == `SERVICE_SECOND && armed_q)
            restart_d = 1'b1;
         else if (wbyte != `SERVICE_FIRST && wbyte != `SERVICE_SECOND)
         begin
            fail_d = 1'b1;
            event_d[`IRQ_BAD_SERVICE] = 1'b1;
         end
      end
      if (expired)
      begin
         fail_d = 1'b1;
         event_d[`IRQ_TIMEOUT] = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         window_q     <= 1'b0;
         debug_stop_q <= 1'b0;
         rate_q       <= 3'h0;
         written_q    <= 1'b0;
      end
      else
      begin
         if (wr && hit_ctrl)
         begin
            if (!wbyte[`BIT_WRITE_MASK] && may_cfg)
            begin
               written_q <= 1'b1;
               if (wbyte[2:0] != 3'h0)
                  rate_q <= wbyte[2:0];
               if (wbyte[`BIT_WINDOW])
                  window_q <= 1'b1;
               else if (special)
                  window_q <= 1'b0;
            end
            if (special)
               debug_stop_q <= wbyte[`BIT_DEBUG_STOP];
            else if (wbyte[`BIT_DEBUG_STOP])
               debug_stop_q <= 1'b1;
         end
      end
   end

   // Service pair tracking and the interrupt mask.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         armed_q   <= 1'b0;
         restart_q <= 1'b0;
         mask_q    <= {`IRQ_WIDTH{1'b0}};
      end
      else
      begin
         restart_q <= restart_d;
         // Repeated first bytes keep the sequence armed.
         if (restart_d)
            armed_q <= 1'b0;
         else if (wr && hit_svc && enabled && wbyte == `SERVICE_FIRST)
            armed_q <= 1'b1;
         if (wr && hit_mask)
            mask_q <= pwdata[`IRQ_WIDTH-1:0];
      end
   end

   // Set wins over a write-one-to-clear in the same cycle.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_q <= {`IRQ_WIDTH{1'b0}};
      else if (wr && hit_stat)
         status_q <= (status_q & ~pwdata[`IRQ_WIDTH-1:0]) | event_d;
      else
         status_q <= status_q | event_d;
   end

   // The reset output is registered, so it follows the cause by one cycle.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         system_reset    <= 1'b0;
         periodic_freeze <= 1'b0;
         irq             <= 1'b0;
      end
      else
      begin
         system_reset    <= fail_d;
         periodic_freeze <= freeze;
         irq             <= |((status_q | event_d) & mask_q);
      end
   end

   // Zero wait states: pready rises in the setup cycle for the access edge.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && hit_none;
         prdata  <= 32'h00000000;
         if (psel && !penable && !pwrite)
            prdata <= rdata_d;
      end
   end
endmodule

// *** core/wdog_defs.vh ***
`ifndef WDOG_DEFS_VH
`define WDOG_DEFS_VH
`define OFF_CONTROL     12'h008
`define OFF_SERVICE     12'h00B
`define OFF_IRQ_STATUS  12'h010
`define OFF_IRQ_MASK    12'h014
`define BIT_WINDOW      7
`define BIT_DEBUG_STOP  6
`define BIT_WRITE_MASK  5
`define CONTROL_RESET   8'h00
`define SERVICE_FIRST   8'h55
`define SERVICE_SECOND  8'hAA
`define IRQ_TIMEOUT     0
`define IRQ_BAD_SERVICE 1
`define IRQ_EARLY       2
`define IRQ_WIDTH       3
`define RATE_MAX        3'h7
`endif

// *** core/wdog_counter.v ***
`include "wdog_defs.vh"
module wdog_counter
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        restart,
   input  wire        run,
   input  wire        freeze,
   input  wire [2:0]  rate,
   output reg         expired,
   output reg         in_window
);
   reg  [23:0] count_q;
   wire [24:0] limit;
   function [24:0] rate_cycles;
      input [2:0] r;
      begin
         case (r)
            3'h1:    rate_cycles = 25'h0004000;
            3'h2:    rate_cycles = 25'h0010000;
            3'h3:    rate_cycles = 25'h0040000;
            3'h4:    rate_cycles = 25'h0100000;
            3'h5:    rate_cycles = 25'h0400000;
            3'h6:    rate_cycles = 25'h0800000;
            default: rate_cycles = 25'h1000000;
         endcase
      end
   endfunction
   assign limit = rate_cycles(rate);
   always @*
   begin
      expired   = run && ({1'b0, count_q} >= limit - 25'h0000001);
      // Last quarter of the period starts at three quarters of the limit.
      in_window = {1'b0, count_q} >= (limit - {2'b00, limit[24:2]});
   end
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_q <= 24'h000000;
      else if (restart || !run)
         count_q <= 24'h000000;
      else if (!freeze && !expired)
         count_q <= count_q + 24'h000001;
   end
endmodule

// *** verification/wdog_checker.sv ***
module wdog_checker
(
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        debug_mode,
   input wire        system_reset,
   input wire        periodic_freeze
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en_q;
   wire  acc = psel && penable && pready;
   // The first nonzero rate write is taken as enabling; a zero write that
   // already spent the single write is not tracked, so that case is weaker.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         en_q <= 1'b0;
      else if (acc && pwrite && paddr == 12'h020 && !pwdata[5] && |pwdata[2:0])
         en_q <= 1'b1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_bad_svc;
      acc && pwrite && paddr == 12'h02C && pwdata[7:0] != 8'h55
         && pwdata[7:0] != 8'hAA;
   endsequence
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_ctrl_bits: assert property (acc && !pwrite && paddr == 12'h020
      |-> prdata[31:8] == 24'h0 && prdata[5:3] == 3'h0)
      else $error("control reserved bits not zero");
   a_svc_zero: assert property (acc && !pwrite && paddr == 12'h02C
      |-> prdata == 32'h0) else $error("service read not zero");
   a_bad_reset: assert property (en_q ##0 s_bad_svc
      |-> ##[1:2] system_reset) else $error("bad service no reset");
   a_quiet_off: assert property (!en_q |-> !system_reset)
      else $error("reset while disabled");
   a_freeze_idle: assert property (!debug_mode [*4] |-> !periodic_freeze)
      else $error("freeze outside debug");
endmodule
bind windowed_watchdog_control wdog_checker chk_i
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .debug_mode, .system_reset, .periodic_freeze
);

// *** verification/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic        special_mode = 0, debug_mode = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, system_reset, periodic_freeze, irq;
   int          err_total = 0, tests_run = 0, rst_cnt = 0, n;
   logic [32:0] q[$];
   logic [7:0]  bad;
   always #2.5 pclk = ~pclk;
   windowed_watchdog_control uut
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .special_mode, .debug_mode, .system_reset,
      .periodic_freeze, .irq
   );
   task chk(input logic [32:0] s, input logic [32:0] e);
      tests_run++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
      if (k >= 50)
         err_total++;
      {psel, penable} <= 2'b0;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask
   task rst;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rst_cnt = 0;
   endtask
   task results;
      if (q.size() != 0)
         err_total++;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Read data is judged at the edge that samples pready, as a master would.
   always @(posedge pclk)
   begin
      if (system_reset === 1'b1)
         rst_cnt++;
      if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
         chk({pslverr, prdata}, q.pop_front());
   end
   initial
   begin
      #450000;
      err_total++;
      results;
   end
   initial
   begin
      n = $urandom(32'hD7E3);
      bad = $urandom;
      if (bad == 8'h55 || bad == 8'hAA)
         bad = 8'h12;
      rst;
      rd(12'h020, 33'h0);
      wr(12'h02C, bad);
      rd(12'h02C, 33'h0);
      wr(12'h020, 8'h27);
      rd(12'h020, 33'h0);
      wr(12'h020, 8'h00);
      wr(12'h020, 8'h83);
      rd(12'h020, 33'h0);
      wr(12'h020, 8'h40);
      wr(12'h020, 8'h00);
      rd(12'h020, 33'h40);
      rd(12'h3FC, 33'h100000000);
      settle;
      chk(33'(rst_cnt), 33'h0);
      special_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      wr(12'h020, 8'h01);
      wr(12'h020, 8'h43);
      rd(12'h020, 33'h43);
      wr(12'h020, 8'h03);
      rd(12'h020, 33'h03);
      wr(12'h020, 8'h43);
      debug_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      settle;
      chk(33'(periodic_freeze), 33'h1);
      debug_mode <= 1'b0;
      special_mode <= 1'b0;
      rst;
      wr(12'h020, 8'h01);
      repeat (10000) @(posedge pclk);
      wr(12'h02C, 8'h55);
      wr(12'h02C, 8'hAA);
      n = 0;
      while (system_reset !== 1'b1 && n < 17000)
      begin
         @(posedge pclk);
         n++;
      end
      chk(33'(n >= 16370 && n <= 16400), 33'h1);
      rd(12'h040, 33'h1);
      rst;
      wr(12'h020, 8'h01);
      wr(12'h02C, bad);
      settle;
      chk(33'(rst_cnt != 0), 33'h1);
      rd(12'h040, 33'h2);
      wr(12'h050, 8'h07);
      settle;
      chk(33'(irq), 33'h1);
      wr(12'h050, 8'h00);
      settle;
      chk(33'(irq), 33'h0);
      wr(12'h040, 8'h07);
      rd(12'h040, 33'h0);
      rst;
      wr(12'h020, 8'h81);
      wr(12'h02C, 8'h55);
      settle;
      chk(33'(rst_cnt != 0), 33'h1);
      rd(12'h040, 33'h4);
      rst;
      wr(12'h020, 8'h81);
      repeat (13000) @(posedge pclk);
      wr(12'h02C, 8'h55);
      wr(12'h02C, 8'h55);
      wr(12'h02C, 8'hAA);
      settle;
      chk(33'(rst_cnt), 33'h0);
      wr(12'h02C, 8'h55);
      settle;
      chk(33'(rst_cnt != 0), 33'h1);
      rst;
      special_mode <= 1'b1;
      debug_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      wr(12'h020, 8'h01);
      repeat (17000) @(posedge pclk);
      chk(33'(rst_cnt), 33'h0);
      debug_mode <= 1'b0;
      repeat (6) @(posedge pclk);
      settle;
      chk(33'(rst_cnt != 0), 33'h1);
      special_mode <= 1'b0;
      results;
   end
endmodule
